// file: design/iccs_defs.vh
// Constants for the I2C control slave port
`ifndef ICCS_DEFS_VH
`define ICCS_DEFS_VH
`define ICCS_ADDR_PREFIX   6'h0F
`define ICCS_CTRL_ADDR     16'h0FFF
`define ICCS_CTRL_RESET    16'h0000
`define ICCS_WIDE_BASE     8'h00
`define ICCS_NARROW_BASE   8'h08
`define ICCS_WIDE_BYTES    2'h3
`define ICCS_NARROW_BYTES  2'h2
`define ICCS_CTRL_BYTES    2'h2
`define ICCS_BIT_INPUT     5
`define ICCS_BIT_CKWS      7
`define ICCS_BIT_OUT3      13
`define ICCS_BIT_MODE      15
`define ICCS_WIDE_W        18
`define ICCS_NARROW_W      12
`define ICCS_DEPTH         256
`endif

// file: design/iccs_sync.v
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module iccs_sync (
	input  wire core_clk, // System clock
	input  wire rst,      // Synchronous reset
	input  wire din,      // Asynchronous pin level
	output reg  dout      // Filtered level
);
	reg s1_reg;
	reg s2_reg;
	reg s3_reg;
	always @(posedge core_clk) begin
		if (rst) begin
			s1_reg <= 1'b1;
			s2_reg <= 1'b1;
			s3_reg <= 1'b1;
			dout   <= 1'b1;
		end else begin
			s1_reg <= din;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg)
				dout <= s3_reg;
		end
	end
endmodule
`default_nettype wire

// file: design/iccs_top.v
// I2C control slave port with control register and two coefficient memories
// Overview of operation
// - Lines idle high; transfers start when idle
// - One bit per SCL pulse; SDA stable high
// - Detect START and STOP at any time
// - Eight bits per byte plus acknowledge pulse
// - Acknowledge every byte received when addressed
// - Release SDA on master's missing acknowledge
// - First byte after START is address byte
// - Address 001111, strap pin, then R/W
// - Slave only; never drives SCL
// - Writes store control or memory; reads memory
// - Two bytes narrow, three bytes wide words
// - Write-only 16-bit control register at 0FFFH
// - Control data high byte then low byte
// - Control fields clear on reset
// - Wide memory 256 by 18 at 0000H
// - Wide word three bytes, 18 of 24 bits
// - Narrow memory 256 by 12 at 0800H
// - Narrow word two bytes, upper nibble ignored
// - Read without address set gets no acknowledge
// - Address auto-increments across successive words, except control writes
// - Reset clears control, reinitialises, releases SDA
`timescale 1ns/1ps
`default_nettype none
`include "iccs_defs.vh"
module iccs_top (
	input  wire core_clk,                  // 50 MHz system clock
	input  wire rst,                       // Synchronous reset, active high
	input  wire scl_in,                    // Bus clock pin, input only
	input  wire sda_in,                    // Bus data pin level
	output reg  sda_out,                   // Bus data drive value
	output reg  sda_oe,                    // Bus data drive enable
	input  wire address_strap_pin,         // Slave address select strap
	output reg  audio_input_choice,        // 0 input one, 1 input two
	output reg  clock_wordsel_out_disable, // Tri-state clock and word select
	output reg  third_data_out_enable,     // Enable third data output
	output reg  flag_tasking_mode,         // 0 flag reset, 1 background tasking
	output reg  [15:0] ctrl_word           // Whole control register
);
	localparam ST_IDLE = 6'h01;
	localparam ST_BITS = 6'h02;
	localparam ST_ACK  = 6'h04;
	localparam ST_TX   = 6'h08;
	localparam ST_RACK = 6'h10;
	localparam ST_WAIT = 6'h20;

	localparam PH_DEV  = 2'h0;
	localparam PH_AH   = 2'h1;
	localparam PH_AL   = 2'h2;
	localparam PH_DATA = 2'h3;

	wire scl_s;
	wire sda_s;
	iccs_sync u_scl (.core_clk(core_clk), .rst(rst), .din(scl_in), .dout(scl_s));
	iccs_sync u_sda (.core_clk(core_clk), .rst(rst), .din(sda_in), .dout(sda_s));

	reg scl_d_reg;
	reg sda_d_reg;
	always @(posedge core_clk) begin
		if (rst) begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
		end
	end
	wire scl_rise = scl_s & ~scl_d_reg;
	wire scl_fall = ~scl_s & scl_d_reg;
	wire start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	wire stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

	reg [`ICCS_WIDE_W-1:0]   wide_mem   [0:`ICCS_DEPTH-1];
	reg [`ICCS_NARROW_W-1:0] narrow_mem [0:`ICCS_DEPTH-1];

	reg [5:0]  state_reg;
	reg [1:0]  phase_reg;
	reg [2:0]  bitcnt_reg;
	reg [7:0]  shift_reg;
	reg        rw_reg;
	reg        addr_valid_reg;
	reg [15:0] addr_reg;
	reg [1:0]  bytecnt_reg;
	reg [23:0] word_reg;
	reg        nack_reg;

	wire is_wide   = (addr_reg[15:8] == `ICCS_WIDE_BASE);
	wire is_narrow = (addr_reg[15:8] == `ICCS_NARROW_BASE);
	wire is_ctrl   = (addr_reg == `ICCS_CTRL_ADDR);
	wire [1:0] word_len = is_wide ? `ICCS_WIDE_BYTES :
		(is_narrow ? `ICCS_NARROW_BYTES : `ICCS_CTRL_BYTES);
	wire [7:0] rx_byte = {shift_reg[6:0], sda_s};
	wire addr_match = (rx_byte[7:2] == `ICCS_ADDR_PREFIX)
		&& (rx_byte[1] == address_strap_pin);
	wire [`ICCS_WIDE_W-1:0]   wide_rd   = wide_mem[addr_reg[7:0]];
	wire [`ICCS_NARROW_W-1:0] narrow_rd = narrow_mem[addr_reg[7:0]];
	wire [23:0] rd_word = is_wide ? {6'h00, wide_rd} : {12'h000, narrow_rd};

	// Byte of the read word selected by bytecnt, high first
	function [7:0] pick_byte;
		input [23:0] w;
		input [1:0]  len;
		input [1:0]  idx;
		reg   [1:0]  pos;
		begin
			pos = len - idx - 2'h1;
			case (pos)
				2'h2:    pick_byte = w[23:16];
				2'h1:    pick_byte = w[15:8];
				default: pick_byte = w[7:0];
			endcase
		end
	endfunction

	always @(posedge core_clk) begin
		if (rst) begin
			state_reg      <= ST_IDLE;
			phase_reg      <= PH_DEV;
			bitcnt_reg     <= 3'h0;
			shift_reg      <= 8'h00;
			rw_reg         <= 1'b0;
			addr_valid_reg <= 1'b0;
			addr_reg       <= 16'h0000;
			bytecnt_reg    <= 2'h0;
			word_reg       <= 24'h000000;
			nack_reg       <= 1'b0;
			sda_out        <= 1'b0;
			sda_oe         <= 1'b0;
			ctrl_word      <= `ICCS_CTRL_RESET;
			audio_input_choice        <= 1'b0;
			clock_wordsel_out_disable <= 1'b0;
			third_data_out_enable     <= 1'b0;
			flag_tasking_mode         <= 1'b0;
		end else begin
			audio_input_choice        <= ctrl_word[`ICCS_BIT_INPUT];
			clock_wordsel_out_disable <= ctrl_word[`ICCS_BIT_CKWS];
			third_data_out_enable     <= ctrl_word[`ICCS_BIT_OUT3];
			flag_tasking_mode         <= ctrl_word[`ICCS_BIT_MODE];
			sda_out <= 1'b0;
			if (start_det) begin
				state_reg   <= ST_BITS;
				phase_reg   <= PH_DEV;
				bitcnt_reg  <= 3'h0;
				bytecnt_reg <= 2'h0;
				sda_oe      <= 1'b0;
			end else if (stop_det) begin
				state_reg <= ST_IDLE;
				sda_oe    <= 1'b0;
			end else begin
				case (state_reg)
					ST_IDLE: begin
						sda_oe <= 1'b0;
					end
					ST_BITS: begin
						if (scl_rise) begin
							shift_reg  <= rx_byte;
							bitcnt_reg <= bitcnt_reg + 3'h1;
							if (bitcnt_reg == 3'h7) begin
								state_reg <= ST_ACK;
								nack_reg  <= 1'b1;
								case (phase_reg)
									PH_DEV: begin
										rw_reg <= rx_byte[0];
										if (addr_match && (!rx_byte[0] || addr_valid_reg)) begin
											nack_reg <= 1'b0;
										end
									end
									PH_AH: begin
										addr_reg[15:8] <= rx_byte;
										addr_valid_reg <= 1'b0;
										nack_reg       <= 1'b0;
									end
									PH_AL: begin
										addr_reg[7:0]  <= rx_byte;
										addr_valid_reg <= 1'b1;
										nack_reg       <= 1'b0;
									end
									default: begin
										word_reg    <= {word_reg[15:0], rx_byte};
										bytecnt_reg <= bytecnt_reg + 2'h1;
										nack_reg    <= 1'b0;
									end
								endcase
							end
						end
					end
					ST_ACK: begin
						// Drive low after the eighth falling edge
						if (scl_fall) begin
							if (!sda_oe) begin
								sda_oe <= ~nack_reg;
								if (nack_reg)
									state_reg <= ST_WAIT;
							end else begin
								sda_oe <= 1'b0;
								bitcnt_reg <= 3'h0;
								case (phase_reg)
									PH_DEV: begin
										phase_reg <= rw_reg ? PH_DATA : PH_AH;
										if (rw_reg) begin
											state_reg   <= ST_TX;
											bytecnt_reg <= 2'h0;
											shift_reg   <= pick_byte(rd_word, word_len, 2'h0);
											sda_oe      <= ~rd_word_msb(pick_byte(rd_word, word_len, 2'h0));
										end else
											state_reg <= ST_BITS;
									end
									PH_AH: begin
										phase_reg <= PH_AL;
										state_reg <= ST_BITS;
									end
									PH_AL: begin
										phase_reg   <= PH_DATA;
										bytecnt_reg <= 2'h0;
										state_reg   <= ST_BITS;
									end
									default: begin
										state_reg <= ST_BITS;
										if (bytecnt_reg == word_len) begin
											bytecnt_reg <= 2'h0;
											if (is_wide)
												wide_mem[addr_reg[7:0]] <= word_reg[`ICCS_WIDE_W-1:0];
											else if (is_narrow)
												narrow_mem[addr_reg[7:0]] <= word_reg[`ICCS_NARROW_W-1:0];
											else if (is_ctrl)
												ctrl_word <= word_reg[15:0];
											if (!is_ctrl)
												addr_reg <= addr_reg + 16'h0001;
										end
									end
								endcase
							end
						end
					end
					ST_TX: begin
						// Shift read data out, MSB first, on falling edges
						if (scl_fall) begin
							if (bitcnt_reg == 3'h7) begin
								sda_oe    <= 1'b0;
								state_reg <= ST_RACK;
							end else begin
								shift_reg  <= {shift_reg[6:0], 1'b0};
								sda_oe     <= ~shift_reg[6];
								bitcnt_reg <= bitcnt_reg + 3'h1;
							end
						end
					end
					ST_RACK: begin
						if (scl_rise) begin
							if (sda_s) begin
								state_reg <= ST_WAIT;
							end else begin
								state_reg <= ST_ACK;
								nack_reg  <= 1'b0;
							end
						end
					end
					ST_WAIT: begin
						sda_oe <= 1'b0;
					end
					default: begin
						state_reg <= ST_IDLE;
						sda_oe    <= 1'b0;
					end
				endcase
				// Master acked a read byte: load next byte on the ack's falling edge
				if (state_reg == ST_ACK && phase_reg == PH_DATA && rw_reg && scl_fall && !nack_reg) begin
					bitcnt_reg <= 3'h0;
					state_reg  <= ST_TX;
					if (bytecnt_reg + 2'h1 == word_len) begin
						bytecnt_reg <= 2'h0;
						addr_reg    <= addr_reg + 16'h0001;
						shift_reg   <= pick_byte(rd_word_next(addr_reg), word_len, 2'h0);
						sda_oe      <= ~rd_word_msb(pick_byte(rd_word_next(addr_reg), word_len, 2'h0));
					end else begin
						bytecnt_reg <= bytecnt_reg + 2'h1;
						shift_reg   <= pick_byte(rd_word, word_len, bytecnt_reg + 2'h1);
						sda_oe      <= ~rd_word_msb(pick_byte(rd_word, word_len, bytecnt_reg + 2'h1));
					end
				end
			end
		end
	end

	function rd_word_msb;
		input [7:0] b;
		begin
			rd_word_msb = b[7];
		end
	endfunction

	// Read word of the next location for auto-increment
	function [23:0] rd_word_next;
		input [15:0] a;
		reg   [7:0]  n;
		begin
			n = a[7:0] + 8'h01;
			rd_word_next = is_wide ? {6'h00, wide_mem[n]} : {12'h000, narrow_mem[n]};
		end
	endfunction
endmodule
`default_nettype wire

// file: verification/iccs_top_sva_sva.sv
// Pin-level assertions for the control slave port
`timescale 1ns/1ps
`default_nettype none
module iccs_top_sva (
	input wire logic        core_clk,                  // Clock
	input wire logic        rst,                       // Reset
	input wire logic        scl_in,                    // Bus clock
	input wire logic        sda_in,                    // Bus data
	input wire logic        sda_out,                   // Drive value
	input wire logic        sda_oe,                    // Drive enable
	input wire logic        audio_input_choice,        // Bit 5
	input wire logic        clock_wordsel_out_disable, // Bit 7
	input wire logic        third_data_out_enable,     // Bit 13
	input wire logic        flag_tasking_mode,         // Bit 15
	input wire logic [15:0] ctrl_word                  // Register
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	a_pull_low_only: assert property (sda_oe |-> !sda_out)
		else $error("data driven high");
	a_reset_quiet: assert property ($fell(rst) |-> !sda_oe && ctrl_word == 16'h0000)
		else $error("reset state wrong");
	a_drive_stable: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
		else $error("data moved with clock high");
	a_drive_in_low: assert property ($rose(sda_oe) |-> !scl_in && !$past(scl_in, 3))
		else $error("drive began near clock high");
	a_ack_holds: assert property ($rose(sda_oe) |-> sda_oe [*8])
		else $error("drive too short");
	a_field_map: assert property (1'b1 |=> {flag_tasking_mode, third_data_out_enable,
		clock_wordsel_out_disable, audio_input_choice}
		== $past({ctrl_word[15], ctrl_word[13], ctrl_word[7], ctrl_word[5]}))
		else $error("field outputs wrong");
	a_ctrl_scl_low: assert property ($changed(ctrl_word) |-> !scl_in)
		else $error("register moved with clock high");
	a_stop_free: assert property ($rose(sda_in) && scl_in |-> !sda_oe)
		else $error("data held at stop");
endmodule
bind iccs_top iccs_top_sva iccs_top_sva_i (.core_clk(core_clk), .rst(rst), .scl_in(scl_in),
	.sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
	.audio_input_choice(audio_input_choice),
	.clock_wordsel_out_disable(clock_wordsel_out_disable),
	.third_data_out_enable(third_data_out_enable),
	.flag_tasking_mode(flag_tasking_mode), .ctrl_word(ctrl_word));
`default_nettype wire

// file: verification/iccs_master.sv
// Bus master model driving the control slave port
`timescale 1ns/1ps
`default_nettype none
module iccs_master (
	output logic      scl,     // Bus clock
	output logic      sda_low, // Pull data low
	input  wire logic sda      // Resolved data line
);
	localparam int Q = 2500; // Quarter of a 100 kHz bit
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task xfer_bit(input logic v, output logic r);
		sda_low = !v;
		#Q scl = 1'b1;
		#Q r = sda;
		#Q scl = 1'b0;
		#Q;
	endtask
	task start;
		sda_low = 1'b0;
		#Q scl = 1'b1;
		#Q sda_low = 1'b1;
		#Q scl = 1'b0;
		#Q;
	endtask
	task stop;
		sda_low = 1'b1;
		#Q scl = 1'b1;
		#Q sda_low = 1'b0;
		#Q;
	endtask
	task put_byte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) xfer_bit(b[i], r);
		xfer_bit(1'b1, r);
		ack = !r;
	endtask
	task get_byte(input logic last, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) xfer_bit(1'b1, b[i]);
		xfer_bit(last, r);
	endtask
endmodule
`default_nettype wire

// file: verification/tb_iccs_top.sv
// Testbench for the control slave port
`timescale 1ns/1ps
`default_nettype none
`include "iccs_defs.vh"
module tb_iccs_top;
	logic        core_clk = 1'b0;
	logic        rst      = 1'b1;
	logic        strap    = 1'b1;
	logic        ack;
	logic [7:0]  rd;
	logic [23:0] w;
	logic [7:0]  wr [6]   = '{8'hFD, 8'h23, 8'h45, 8'hFE, 8'h67, 8'h89};
	wire         scl, sda_low, sda, sda_out, sda_oe, sel, ckws, out3, mode;
	wire  [15:0] ctrl;
	int          bad_count  = 0;
	int          n_compared = 0;
	assign sda = !((sda_oe & !sda_out) | sda_low);
	iccs_master iccs_master_i (.scl(scl), .sda_low(sda_low), .sda(sda));
	iccs_top iccs_top_i (.core_clk(core_clk), .rst(rst), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .address_strap_pin(strap),
		.audio_input_choice(sel), .clock_wordsel_out_disable(ckws),
		.third_data_out_enable(out3), .flag_tasking_mode(mode), .ctrl_word(ctrl));
	initial forever #10 core_clk = ~core_clk;
	task close_out;
		if (bad_count == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task check(input string what, input logic [17:0] exp, input logic [17:0] got);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask
	task send(input logic [7:0] b);
		iccs_master_i.put_byte(b, ack);
		check("ack", 18'h00001, {17'h00000, ack});
	endtask
	task set_addr(input logic [15:0] a);
		iccs_master_i.start;
		send({`ICCS_ADDR_PREFIX, strap, 1'b0});
		send(a[15:8]);
		send(a[7:0]);
	endtask
	task refused(input logic [7:0] b);
		iccs_master_i.start;
		iccs_master_i.put_byte(b, ack);
		check("nack", 18'h00000, {17'h00000, ack});
		iccs_master_i.stop;
	endtask
	initial begin
		repeat (112000) @(posedge core_clk);
		bad_count++;
		close_out;
	end
	initial begin
		repeat (8) @(posedge core_clk);
		#1 rst = 1'b0;
		repeat (10) @(posedge core_clk);
		#1;
		check("ctrl", 18'h00000, {2'h0, ctrl});
		refused({`ICCS_ADDR_PREFIX, strap, 1'b1});
		refused({`ICCS_ADDR_PREFIX, !strap, 1'b0});
		set_addr(`ICCS_CTRL_ADDR);
		send(8'hA0);
		send(8'hA0);
		iccs_master_i.stop;
		check("ctrl", 18'h0A0A0, {2'h0, ctrl});
		check("fields", 18'h0000F, {14'h0, mode, out3, ckws, sel});
		set_addr(16'h00FE);
		foreach (wr[i]) send(wr[i]);
		iccs_master_i.stop;
		set_addr(16'h00FF);
		iccs_master_i.start;
		send({`ICCS_ADDR_PREFIX, strap, 1'b1});
		for (int i = 0; i < 3; i++) begin
			iccs_master_i.get_byte(i == 2, rd);
			w = {w[15:0], rd};
		end
		iccs_master_i.stop;
		check("wide word", 18'h26789, w[17:0]);
		check("ctrl kept", 18'h0A0A0, {2'h0, ctrl});
		@(posedge core_clk);
		#1 rst = 1'b1;
		repeat (8) @(posedge core_clk);
		#1;
		check("ctrl reset", 18'h00000, {2'h0, ctrl});
		check("fields reset", 18'h00000, {14'h0, mode, out3, ckws, sel});
		close_out;
	end
endmodule
`default_nettype wire
